// file: rcss_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module rcss_assertions (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        external_reset_n_pin,
   input wire logic        watchdog_timeout,
   input wire logic        halt_enter,
   input wire logic        wake_event,
   input wire logic        clear_watchdog_instr,
   input wire logic        rd,
   input wire logic [7:0]  rdata,
   input wire logic        core_reset,
   input wire logic        core_run,
   input wire logic [12:0] program_counter,
   input wire logic        timeout_flag,
   input wire logic        powerdown_flag,
   input wire logic [7:0]  watchdog_prescale_select,
   input wire logic [6:0]  interrupt_control,
   input wire logic [7:0]  timer0_control,
   input wire logic [4:0]  timer1_control,
   input wire logic [7:0]  port_b_data
);
   logic [15:0] not_run_cnt;
   logic        in_halt;
   logic [15:0] wake_cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // cycles spent outside run
   always_ff @(posedge clk) begin
      if (rst || core_run) not_run_cnt <= 16'h0000;
      else if (not_run_cnt != 16'hFFFF) not_run_cnt <= not_run_cnt + 16'h0001;
   end
   // tracks halt between entry and wake
   always_ff @(posedge clk) begin
      if (rst || core_reset) in_halt <= 1'b0;
      else if (halt_enter && core_run) in_halt <= 1'b1;
      else if (wake_event || watchdog_timeout) in_halt <= 1'b0;
   end
   // cycles since a wake from halt, cleared once run resumes or on reset
   always_ff @(posedge clk) begin
      if (rst || core_reset || core_run) wake_cnt <= 16'h0000;
      else if (in_halt && (wake_event || watchdog_timeout)) wake_cnt <= 16'h0001;
      else if (wake_cnt != 16'h0000) wake_cnt <= wake_cnt + 16'h0001;
   end
   chk_pin_holds_core: assert property (!external_reset_n_pin [*4] |-> core_reset)
      else $error("pin low did not hold core");
   chk_startup_long: assert property ($rose(core_run) |-> not_run_cnt >= 16'h0400)
      else $error("run began before startup delay");
   chk_wdt_run_full: assert property (watchdog_timeout && core_run && !clear_watchdog_instr
      |=> timeout_flag && core_reset && $stable(powerdown_flag)) else $error("bad watchdog reset");
   chk_warm_reset: assert property (in_halt && watchdog_timeout |=> timeout_flag
      && powerdown_flag && program_counter == 13'h0000 && !core_reset
      && $stable(watchdog_prescale_select) && $stable(port_b_data)) else $error("bad warm reset");
   chk_reset_values: assert property ($fell(core_reset) |-> program_counter == 13'h0000
      && watchdog_prescale_select == 8'h07 && interrupt_control == 7'h00
      && timer0_control == 8'h08 && timer1_control == 5'h01) else $error("bad reset values");
   chk_halt_flags: assert property (halt_enter && core_run && !watchdog_timeout
      && !clear_watchdog_instr |=> powerdown_flag && !timeout_flag) else $error("bad halt flags");
   chk_clear_flags: assert property (clear_watchdog_instr && core_run && !watchdog_timeout
      && !halt_enter |=> !powerdown_flag && !timeout_flag) else $error("flags not cleared");
   chk_wake_delay: assert property (in_halt && wake_event |=>
      (!core_run && !core_reset) [*8]) else $error("bad wake delay");
   // run state entered 1024 cycles after the wake edge, seen one edge later
   chk_wake_length: assert property ($rose(core_run) && wake_cnt != 16'h0000
      |-> wake_cnt == 16'h0401) else $error("wake delay not 1024 cycles");
   chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data without read");
endmodule : rcss_assertions
bind rcss_top rcss_assertions i_chk (.clk(clk), .rst(rst),
   .external_reset_n_pin(external_reset_n_pin), .watchdog_timeout(watchdog_timeout),
   .halt_enter(halt_enter), .wake_event(wake_event), .clear_watchdog_instr(clear_watchdog_instr),
   .rd(rd), .rdata(rdata), .core_reset(core_reset), .core_run(core_run),
   .program_counter(program_counter), .timeout_flag(timeout_flag),
   .powerdown_flag(powerdown_flag), .watchdog_prescale_select(watchdog_prescale_select),
   .interrupt_control(interrupt_control), .timer0_control(timer0_control),
   .timer1_control(timer1_control), .port_b_data(port_b_data));
`default_nettype wire

// file: rcss_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module rcss_core_model (
   input  wire logic clk,
   input  wire logic core_reset,
   input  wire logic core_run,
   output int        run_cycles
);
   // executed cycles since the last core reset
   always_ff @(posedge clk) begin
      if (core_reset) run_cycles <= 0;
      else if (core_run) run_cycles <= run_cycles + 1;
   end
endmodule : rcss_core_model
`default_nettype wire

// file: rcss_pkg.sv
package rcss_pkg;
   typedef enum logic [2:0] {
      RCSS_HOLD, RCSS_DELAY, RCSS_RUN, RCSS_HALT, RCSS_WAKE
   } rcss_state_t;
   typedef enum logic [2:0] {
      RCSS_C_POWER, RCSS_C_PIN_RUN, RCSS_C_PIN_HALT, RCSS_C_WDT_RUN, RCSS_C_WDT_HALT,
      RCSS_C_WAKE
   } rcss_cause_t;
endpackage : rcss_pkg

// file: rcss_regs.svh
// What this block does
// RQ1: three chip reset sources start full reset
// RQ2: watchdog in halt resets only pc, sp
// RQ3: timeout and powerdown flags set per cause
// RQ4: 1024 clock startup delay after resets, wakes
// RQ5: delay added to reset; wake waits delay
// RQ6: chip reset: pc zero, ints off, timers off
// RQ7: chip reset clears watchdog, restarts counting
// RQ8: non-warm reset loads prescale select 07
// RQ9: warm reset keeps registers, pc to zero
// RQ10: pointers, accumulator never changed by reset
// RQ11: non-warm reset sets port registers ones
// RQ12: non-warm reset loads interrupt, timer controls
// RQ13: timer counts untouched by reset here
// RQ14: status flag bits read per cause
// RQ15: pin synchronised, core held until delay
// RQ16: halt sets powerdown, clear instr clears it
`ifndef RCSS_REGS_SVH
`define RCSS_REGS_SVH
`define RCSS_STARTUP_CYCLES   11'h400
`define RCSS_CNT_ONE          11'h001
`define RCSS_CNT_ZERO         11'h000
`define RCSS_PC_RESET         13'h0000
`define RCSS_SP_RESET         3'h0
`define RCSS_WATCHDOG_PRESCALE_SELECT_RESET       8'h07
`define RCSS_INTERRUPT_CONTROL_RESET       7'h00
`define RCSS_TIMER0_CONTROL_RESET      8'h08
`define RCSS_TIMER1_CONTROL_RESET      5'h01
`define RCSS_PORT8_RESET      8'hFF
`define RCSS_PORT6_RESET      6'h3F
`define RCSS_PORT1_RESET      1'h1
`define RCSS_A_WATCHDOG_PRESCALE_SELECT           5'h00
`define RCSS_A_INTERRUPT_CONTROL           5'h01
`define RCSS_A_TIMER0_CONTROL          5'h02
`define RCSS_A_TIMER1_CONTROL          5'h03
`define RCSS_A_PA             5'h04
`define RCSS_A_PAC            5'h05
`define RCSS_A_PB             5'h06
`define RCSS_A_PBC            5'h07
`define RCSS_A_PCD            5'h08
`define RCSS_A_PCC            5'h09
`define RCSS_A_PF             5'h0A
`define RCSS_A_PFC            5'h0B
`define RCSS_A_STATUS         5'h0C
`define RCSS_A_CAUSE          5'h0D
`define RCSS_ST_TO            5
`define RCSS_ST_PD            4
`endif

// file: rcss_top.sv
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "rcss_regs.svh"
module rcss_top (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        external_reset_n_pin,
   input  wire logic        watchdog_timeout,
   input  wire logic        halt_enter,
   input  wire logic        wake_event,
   input  wire logic        clear_watchdog_instr,
   input  wire logic [4:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [7:0]  rdata,
   output logic             core_reset,
   output logic             core_run,
   output logic             pc_sp_clear,
   output logic             watchdog_clear,
   output logic             prescaler_clear,
   output logic             timer_count_keep,
   output logic      [12:0] program_counter,
   output logic      [2:0]  stack_pointer,
   output logic             timeout_flag,
   output logic             powerdown_flag,
   output logic      [7:0]  watchdog_prescale_select,
   output logic      [6:0]  interrupt_control,
   output logic      [7:0]  timer0_control,
   output logic      [4:0]  timer1_control,
   output logic      [7:0]  port_a_data,
   output logic      [7:0]  port_a_direction,
   output logic      [7:0]  port_b_data,
   output logic      [7:0]  port_b_direction,
   output logic      [5:0]  port_c_data,
   output logic      [5:0]  port_c_direction,
   output logic             port_f_data,
   output logic             port_f_direction
);
   rcss_pkg::rcss_state_t state;
   rcss_pkg::rcss_cause_t cause;
   logic        pin_meta;
   logic        pin_sync;
   logic [10:0] startup_delay_timer;
   logic        pin_low;
   logic        full_reset;
   logic        warm_reset;
   logic        in_halt;

   // two-stage pin synchroniser
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
      end else begin
         pin_meta <= external_reset_n_pin;
         pin_sync <= pin_meta;                          // [RQ15]
      end
   end

   assign pin_low = ~pin_sync;
   assign in_halt = (state == rcss_pkg::RCSS_HALT);
   // full chip reset from pin in any state but hold, or watchdog in run
   assign full_reset = (state == rcss_pkg::RCSS_RUN && watchdog_timeout)
                     || (pin_low && state != rcss_pkg::RCSS_HOLD);   // [RQ1]
   // watchdog while halted wakes with pc and sp cleared only
   assign warm_reset = in_halt && watchdog_timeout && !pin_low;       // [RQ2]

   // sequencer: hold while pin low, then startup delay, run
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= rcss_pkg::RCSS_HOLD;
      end else begin
         case (state)
            rcss_pkg::RCSS_HOLD: begin
               if (!pin_low) begin
                  state <= rcss_pkg::RCSS_DELAY;         // [RQ15]
               end
            end
            rcss_pkg::RCSS_DELAY, rcss_pkg::RCSS_WAKE: begin
               if (pin_low) begin
                  state <= rcss_pkg::RCSS_HOLD;
               end else if (startup_delay_timer == `RCSS_CNT_ONE) begin
                  state <= rcss_pkg::RCSS_RUN;           // [RQ4]
               end
            end
            rcss_pkg::RCSS_RUN: begin
               if (full_reset) begin
                  state <= pin_low ? rcss_pkg::RCSS_HOLD : rcss_pkg::RCSS_DELAY;  // [RQ5]
               end else if (halt_enter) begin
                  state <= rcss_pkg::RCSS_HALT;
               end
            end
            rcss_pkg::RCSS_HALT: begin
               if (pin_low) begin
                  state <= rcss_pkg::RCSS_HOLD;
               end else if (warm_reset || wake_event) begin
                  state <= rcss_pkg::RCSS_WAKE;          // [RQ5]
               end
            end
            default: begin
               state <= rcss_pkg::RCSS_HOLD;
            end
         endcase
      end
   end

   // startup delay counter loaded on entry to delay or wake
   always_ff @(posedge clk) begin
      if (rst) begin
         startup_delay_timer <= `RCSS_STARTUP_CYCLES;
      end else if (state == rcss_pkg::RCSS_HOLD || state == rcss_pkg::RCSS_RUN
                   || state == rcss_pkg::RCSS_HALT) begin
         startup_delay_timer <= `RCSS_STARTUP_CYCLES;   // [RQ4]
      end else if (startup_delay_timer != `RCSS_CNT_ZERO) begin
         startup_delay_timer <= startup_delay_timer - `RCSS_CNT_ONE;
      end
   end

   // reset cause for software
   always_ff @(posedge clk) begin
      if (rst) begin
         cause <= rcss_pkg::RCSS_C_POWER;
      end else if (state == rcss_pkg::RCSS_RUN && pin_low) begin
         cause <= rcss_pkg::RCSS_C_PIN_RUN;
      end else if (in_halt && pin_low) begin
         cause <= rcss_pkg::RCSS_C_PIN_HALT;
      end else if (state == rcss_pkg::RCSS_RUN && watchdog_timeout) begin
         cause <= rcss_pkg::RCSS_C_WDT_RUN;
      end else if (warm_reset) begin
         cause <= rcss_pkg::RCSS_C_WDT_HALT;
      end else if (in_halt && wake_event) begin
         cause <= rcss_pkg::RCSS_C_WAKE;
      end
   end

   // timeout and powerdown flags
   always_ff @(posedge clk) begin
      if (rst) begin
         timeout_flag   <= 1'b0;                         // [RQ3]
         powerdown_flag <= 1'b0;
      end else if (state == rcss_pkg::RCSS_RUN && pin_low) begin
         timeout_flag   <= timeout_flag;                 // [RQ3]
         powerdown_flag <= powerdown_flag;
      end else if (in_halt && pin_low) begin
         timeout_flag   <= 1'b0;                         // [RQ3] [RQ14]
         powerdown_flag <= 1'b1;
      end else if (state == rcss_pkg::RCSS_RUN && watchdog_timeout) begin
         timeout_flag   <= 1'b1;                         // [RQ3] [RQ14]
      end else if (warm_reset) begin
         timeout_flag   <= 1'b1;                         // [RQ3] [RQ14]
         powerdown_flag <= 1'b1;
      end else if (state == rcss_pkg::RCSS_RUN && halt_enter) begin
         timeout_flag   <= 1'b0;
         powerdown_flag <= 1'b1;                         // [RQ16]
      end else if (state == rcss_pkg::RCSS_RUN && clear_watchdog_instr) begin
         timeout_flag   <= 1'b0;
         powerdown_flag <= 1'b0;                         // [RQ16]
      end
   end

   // program counter and stack pointer, cleared by every reset
   always_ff @(posedge clk) begin
      if (rst || full_reset || warm_reset) begin
         program_counter <= `RCSS_PC_RESET;              // [RQ6] [RQ9]
         stack_pointer   <= `RCSS_SP_RESET;              // [RQ2] [RQ6]
      end
   end

   // strobes to core and watchdog
   assign core_reset       = rst || state == rcss_pkg::RCSS_HOLD
                           || state == rcss_pkg::RCSS_DELAY;  // [RQ5] [RQ15]
   assign core_run         = (state == rcss_pkg::RCSS_RUN);
   assign pc_sp_clear      = rst || full_reset || warm_reset; // [RQ2]
   assign watchdog_clear   = rst || full_reset || state == rcss_pkg::RCSS_HOLD;  // [RQ7]
   assign prescaler_clear  = rst || full_reset;               // [RQ6]
   // timer counts, pointers and accumulator are never touched here
   assign timer_count_keep = 1'b1;                            // [RQ10] [RQ13]

   // watchdog prescale select
   always_ff @(posedge clk) begin
      if (rst || full_reset) begin
         watchdog_prescale_select <= `RCSS_WATCHDOG_PRESCALE_SELECT_RESET;   // [RQ8]
      end else if (wr && addr == `RCSS_A_WATCHDOG_PRESCALE_SELECT) begin
         watchdog_prescale_select <= wdata;
      end
   end

   // interrupt and timer controls
   always_ff @(posedge clk) begin
      if (rst || full_reset) begin
         interrupt_control <= `RCSS_INTERRUPT_CONTROL_RESET;          // [RQ6] [RQ12]
         timer0_control    <= `RCSS_TIMER0_CONTROL_RESET;         // [RQ12]
         timer1_control    <= `RCSS_TIMER1_CONTROL_RESET;         // [RQ12]
      end else if (wr) begin
         if (addr == `RCSS_A_INTERRUPT_CONTROL) begin
            interrupt_control <= {wdata[6:4], 1'b0, wdata[2:0]};
         end
         if (addr == `RCSS_A_TIMER0_CONTROL) begin
            timer0_control <= {wdata[7:6], 1'b0, wdata[4:0]};
         end
         if (addr == `RCSS_A_TIMER1_CONTROL) begin
            timer1_control <= {wdata[7:6], 1'b0, wdata[4:3]};
         end
      end
   end

   // port data and direction, inputs after reset
   always_ff @(posedge clk) begin
      if (rst || full_reset) begin
         port_a_data      <= `RCSS_PORT8_RESET;          // [RQ11]
         port_a_direction <= `RCSS_PORT8_RESET;          // [RQ6] [RQ11]
         port_b_data      <= `RCSS_PORT8_RESET;
         port_b_direction <= `RCSS_PORT8_RESET;
         port_c_data      <= `RCSS_PORT6_RESET;
         port_c_direction <= `RCSS_PORT6_RESET;
         port_f_data      <= `RCSS_PORT1_RESET;
         port_f_direction <= `RCSS_PORT1_RESET;
      end else if (wr) begin
         case (addr)
            `RCSS_A_PA:  port_a_data      <= wdata;
            `RCSS_A_PAC: port_a_direction <= wdata;
            `RCSS_A_PB:  port_b_data      <= wdata;
            `RCSS_A_PBC: port_b_direction <= wdata;
            `RCSS_A_PCD: port_c_data      <= wdata[5:0];
            `RCSS_A_PCC: port_c_direction <= wdata[5:0];
            `RCSS_A_PF:  port_f_data      <= wdata[0];
            `RCSS_A_PFC: port_f_direction <= wdata[0];
            default: begin
            end
         endcase
      end
   end

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge clk) begin
      if (rst || !rd) begin
         rdata <= 8'h00;
      end else begin
         case (addr)
            `RCSS_A_WATCHDOG_PRESCALE_SELECT:   rdata <= watchdog_prescale_select;
            `RCSS_A_INTERRUPT_CONTROL:   rdata <= {1'b0, interrupt_control};
            `RCSS_A_TIMER0_CONTROL:  rdata <= timer0_control;
            `RCSS_A_TIMER1_CONTROL:  rdata <= {timer1_control, 3'h0};
            `RCSS_A_PA:     rdata <= port_a_data;
            `RCSS_A_PAC:    rdata <= port_a_direction;
            `RCSS_A_PB:     rdata <= port_b_data;
            `RCSS_A_PBC:    rdata <= port_b_direction;
            `RCSS_A_PCD:    rdata <= {2'h0, port_c_data};
            `RCSS_A_PCC:    rdata <= {2'h0, port_c_direction};
            `RCSS_A_PF:     rdata <= {7'h00, port_f_data};
            `RCSS_A_PFC:    rdata <= {7'h00, port_f_direction};
            `RCSS_A_STATUS: rdata <= {2'h0, timeout_flag, powerdown_flag, 4'h0};  // [RQ14]
            `RCSS_A_CAUSE:  rdata <= {5'h00, cause};
            default:        rdata <= 8'h00;
         endcase
      end
   end
endmodule : rcss_top
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "rcss_regs.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
   $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
   logic        clk = 1'b0, rst = 1'b1, ext_rst_n = 1'b1, wdt = 1'b0, hlt = 1'b0, wk = 1'b0;
   logic        pcsp_clr, wdt_clr, psc_clr, cnt_keep;
   logic        clr = 1'b0, wr = 1'b0, rd = 1'b0, core_reset, core_run, to_f, pd_f;
   logic [4:0]  addr = 5'h00;
   logic [7:0]  wdata = 8'h00, rdata;
   logic [12:0] pc;
   int          err_total = 0, samples_checked = 0, run_cycles, n, m;
   rcss_top i_rcss_top (.clk(clk), .rst(rst), .external_reset_n_pin(ext_rst_n),
      .watchdog_timeout(wdt), .halt_enter(hlt), .wake_event(wk), .clear_watchdog_instr(clr),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .core_reset(core_reset),
      .core_run(core_run), .pc_sp_clear(pcsp_clr), .watchdog_clear(wdt_clr),
      .prescaler_clear(psc_clr), .timer_count_keep(cnt_keep), .program_counter(pc),
      .stack_pointer(), .timeout_flag(to_f),
      .powerdown_flag(pd_f), .watchdog_prescale_select(), .interrupt_control(),
      .timer0_control(), .timer1_control(), .port_a_data(), .port_a_direction(),
      .port_b_data(), .port_b_direction(), .port_c_data(), .port_c_direction(),
      .port_f_data(), .port_f_direction());
   rcss_core_model i_rcss_core_model (.clk(clk), .core_reset(core_reset),
      .core_run(core_run), .run_cycles(run_cycles));
   // 10 MHz clock
   always #50 clk = ~clk;
   task give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   task wr_reg(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
      @(posedge clk) wr <= 1'b0;
   endtask : wr_reg
   task rd_chk(input logic [4:0] a, input logic [7:0] e);
      @(posedge clk) begin addr <= a; rd <= 1'b1; end
      @(posedge clk) rd <= 1'b0;
      #1 `CHK(rdata, e)
   endtask : rd_chk
   // one-cycle strobe: 0 halt, 1 wake, 2 watchdog, 3 clear
   task pulse(input int k);
      @(posedge clk) case (k)
         0: hlt <= 1'b1;
         1: wk <= 1'b1;
         2: wdt <= 1'b1;
         default: clr <= 1'b1;
      endcase
      @(posedge clk) {hlt, wk, wdt, clr} <= 4'h0;
      #1;
   endtask : pulse
   task wait_run;
      n = 0;
      while (core_run !== 1'b1 && n < 3000) begin
         @(posedge clk);
         #1;
         n++;
      end
      `CHK(core_run, 1'b1)
      #1;
   endtask : wait_run
   task pin_reset;
      @(posedge clk) ext_rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      ext_rst_n <= 1'b1;
      wait_run();
   endtask : pin_reset
   task t_power;
      wait_run();
      `CHK(n >= 1024 && n <= 1030, 1'b1)
      `CHK({to_f, pd_f}, 2'b00)
      `CHK(pc, 13'h0000)
      `CHK(cnt_keep, 1'b1)
      rd_chk(`RCSS_A_WATCHDOG_PRESCALE_SELECT, 8'h07);
      rd_chk(`RCSS_A_INTERRUPT_CONTROL, 8'h00);
      rd_chk(`RCSS_A_TIMER0_CONTROL, 8'h08);
      rd_chk(`RCSS_A_TIMER1_CONTROL, 8'h08);
      rd_chk(`RCSS_A_PAC, 8'hFF);
      rd_chk(`RCSS_A_PCD, 8'h3F);
      rd_chk(`RCSS_A_PFC, 8'h01);
      rd_chk(5'h1F, 8'h00);
      $display("test power done");
   endtask : t_power
   task t_halt_wake;
      wr_reg(`RCSS_A_WATCHDOG_PRESCALE_SELECT, 8'h55);
      pulse(0);
      `CHK({to_f, pd_f}, 2'b01)
      pulse(1);
      wait_run();
      `CHK(n, 1024)
      rd_chk(`RCSS_A_WATCHDOG_PRESCALE_SELECT, 8'h55);
      $display("test halt wake done");
   endtask : t_halt_wake
   task t_pin_run;
      pin_reset();
      `CHK({to_f, pd_f}, 2'b01)
      rd_chk(`RCSS_A_WATCHDOG_PRESCALE_SELECT, 8'h07);
      pulse(3);
      `CHK({to_f, pd_f}, 2'b00)
      $display("test pin run done");
   endtask : t_pin_run
   task t_wdt_run;
      wr_reg(`RCSS_A_PA, 8'h12);
      rd_chk(`RCSS_A_PA, 8'h12);
      @(posedge clk) wdt <= 1'b1;
      #1 `CHK({pcsp_clr, wdt_clr, psc_clr}, 3'b111)
      @(posedge clk) wdt <= 1'b0;
      #1;
      wait_run();
      `CHK({to_f, pd_f}, 2'b10)
      rd_chk(`RCSS_A_PA, 8'hFF);
      rd_chk(`RCSS_A_STATUS, 8'h20);
      $display("test watchdog run done");
   endtask : t_wdt_run
   task t_wdt_halt;
      wr_reg(`RCSS_A_WATCHDOG_PRESCALE_SELECT, 8'h33);
      wr_reg(`RCSS_A_PB, 8'h5A);
      m = run_cycles;
      pulse(0);
      @(posedge clk) wdt <= 1'b1;
      #1 `CHK({pcsp_clr, wdt_clr, psc_clr}, 3'b100)
      @(posedge clk) wdt <= 1'b0;
      #1 `CHK(pc, 13'h0000)
      wait_run();
      `CHK(run_cycles > m, 1'b1)
      `CHK({to_f, pd_f}, 2'b11)
      rd_chk(`RCSS_A_WATCHDOG_PRESCALE_SELECT, 8'h33);
      rd_chk(`RCSS_A_PB, 8'h5A);
      rd_chk(`RCSS_A_STATUS, 8'h30);
      rd_chk(`RCSS_A_CAUSE, {5'h00, rcss_pkg::RCSS_C_WDT_HALT});
      $display("test warm reset done");
   endtask : t_wdt_halt
   task t_pin_halt;
      pulse(0);
      pin_reset();
      `CHK({to_f, pd_f}, 2'b01)
      rd_chk(`RCSS_A_PB, 8'hFF);
      $display("test pin halt done");
   endtask : t_pin_halt
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_power();
      t_halt_wake();
      t_pin_run();
      t_wdt_run();
      t_wdt_halt();
      t_pin_halt();
      give_verdict();
   end
   // cuts a hang short
   initial begin
      #2000000;
      err_total++;
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
